// *** include/psf_map.svh ***
/*
 Timing, index and level constants of the primary-side fault sequencer.
 Assumes a 125 MHz system clock and a 1 us enable tick derived from it.
*/
`ifndef PSF_MAP_SVH
`define PSF_MAP_SVH

// ----------------------------------------------------------------
// Clock and tick
// ----------------------------------------------------------------
`define PSF_CLK_MHZ 125
`define PSF_TICK_CYC (`PSF_CLK_MHZ)

// ----------------------------------------------------------------
// Times in their own units, and derived counts
// ----------------------------------------------------------------
`define PSF_T_SOA_NS 500
`define PSF_SOA_CYC ((`PSF_T_SOA_NS * `PSF_CLK_MHZ) / 1000)
`define PSF_T_SKIP_US 25
`define PSF_T_HS_GAP_US 30
`define PSF_HS_MIN_US (`PSF_T_HS_GAP_US / 2)
`define PSF_HS_MAX_US (`PSF_T_HS_GAP_US * 2)
`define PSF_T_LINE_OFF_US 50
`define PSF_T_RESTART_ON_MS 82
`define PSF_RESTART_ON_US (`PSF_T_RESTART_ON_MS * 1000)

// ----------------------------------------------------------------
// Current limit, percent of full scale
// ----------------------------------------------------------------
`define PSF_PEAK_CURRENT_LIMIT_FULL 7'h64
`define PSF_PEAK_CURRENT_LIMIT_FLOOR 7'h1e
`define PSF_JIT_DEPTH 3'h5

// ----------------------------------------------------------------
// Synchronised comparator vector bit positions
// ----------------------------------------------------------------
`define PSF_IN_SUPPLY_LOW 0
`define PSF_IN_SUPPLY_SHUNT 1
`define PSF_IN_SUPPLY_CLEAR 2
`define PSF_IN_SUPPLY_OVC 3
`define PSF_IN_TEMP_HOT 4
`define PSF_IN_TEMP_COOL 5
`define PSF_IN_BROWN_IN 6
`define PSF_IN_BROWN_OUT 7
`define PSF_IN_LINE_OV 8
`define PSF_IN_LINE_UV 9
`define PSF_IN_CAP_LARGE 10
`define PSF_IN_LIMIT_HIT 11
`define PSF_IN_REQ 12
`define PSF_IN_WIDTH 13

`endif

// *** include/psf_pkg.sv ***
/*
 Types of the primary-side fault sequencer.
 Assumes psf_map.svh carries the shared numeric constants; timer defaults are psf_sequencer parameters.
*/
package psf_pkg;
   typedef enum logic [6:0] {
      PSF_INIT = 7'h01,
      PSF_LINE = 7'h02,
      PSF_WAIT = 7'h04,
      PSF_PRIM = 7'h08,
      PSF_SLAVE = 7'h10,
      PSF_AROFF = 7'h20,
      PSF_LATCH = 7'h40
   } psf_state_e;
   typedef logic [23:0] psf_count_t;
endpackage

// *** design/psf_sequencer.sv ***
/*
 Primary-side control and protection sequencer of a flyback switcher.
 Assumes analog comparators and the link receiver drive level inputs
 asynchronous to clk_sys; the power stage follows switchOn and compares
 primary current against ilimPct.
*/
// Overview of operation
// - Bypass capacitor size latches current-limit level
// - Supply undervoltage blocks switch until shunt level
// - Supply overcurrent latches off or auto-restarts
// - Hysteretic thermal block clears after cooling
// - Latched thermal clears on supply or line low
// - Latched faults clear at supply or line low
// - Limit ramps with time since switch off
// - Limit floors at thirty percent of full
// - Limit jitters between full and ninety-five percent
// - Sustained overload requests force auto-restart
// - Request silence timeout forces auto-restart
// - Line reset clears auto-restart at once
// - Two early limit hits skip switching
// - Line checked in range before first cycle
// - Filtered brown-out restarts, resume above brown-in
// - Line overvoltage restarts until back in range
// - Long off time disconnects line sense
// - Self switching without feedback, restart on timeout
// - Control handed over only after handshake
// - Listen one restart on time before switching
`timescale 1ns/10ps
`default_nettype none
`include "psf_map.svh"

module psf_sequencer #(
   parameter int unsigned RESTART_OFF_US = 1500000,
   parameter int unsigned SILENCE_US = 1500000,
   parameter int unsigned BROWNOUT_US = 30000,
   parameter int unsigned RESTART_ON_US = `PSF_RESTART_ON_US,
   parameter int unsigned OVL_GAP_US = 8,
   parameter int unsigned PRIM_PERIOD_US = 40,
   parameter int unsigned MAX_ON_CYC = 1250,
   parameter int unsigned RAMP_DIV_US = 2,
   parameter int unsigned JIT_STEP_US = 100
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Supply comparators
   input wire logic supplyLow,
   input wire logic supplyShunt,
   input wire logic supplyClear,
   input wire logic supplyOverCurrent,
   input wire logic capLarge,
   // Thermal comparators
   input wire logic tempHot,
   input wire logic tempCool,
   // Line comparators
   input wire logic lineBrownIn,
   input wire logic lineBrownOut,
   input wire logic lineOver,
   input wire logic lineUnder,
   // Power stage and link
   input wire logic limitHit,
   input wire logic cycleRequest,
   // Option straps
   input wire logic optSupplyLatch,
   input wire logic optThermalLatch,
   // Power stage control
   output logic switchOn,
   output logic [6:0] ilimPct,
   output logic ilimHigh,
   output logic lineSenseOn,
   // Status
   output logic slaveMode,
   output logic autoRestart,
   output logic latchedOff,
   output psf_pkg::psf_state_e fsmState
);
   import psf_pkg::*;

   function automatic psf_count_t psfIncr(input psf_count_t v);
      return (v == 24'hffffff) ? v : v + 24'h1;
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [`PSF_IN_WIDTH-1:0] rawIn;
   logic [`PSF_IN_WIDTH-1:0] syncA;
   logic [`PSF_IN_WIDTH-1:0] syncB;
   logic reqPrev;

   assign rawIn = {cycleRequest, limitHit, capLarge, lineUnder, lineOver,
                   lineBrownOut, lineBrownIn, tempCool, tempHot,
                   supplyOverCurrent, supplyClear, supplyShunt, supplyLow};

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         syncA <= '0;
         syncB <= '0;
         reqPrev <= 1'b0;
      end else begin
         syncA <= rawIn;
         syncB <= syncA;
         reqPrev <= syncB[`PSF_IN_REQ];
      end
   end

   wire sLow = syncB[`PSF_IN_SUPPLY_LOW];
   wire sShunt = syncB[`PSF_IN_SUPPLY_SHUNT];
   wire sClear = syncB[`PSF_IN_SUPPLY_CLEAR];
   wire sOvc = syncB[`PSF_IN_SUPPLY_OVC];
   wire sHot = syncB[`PSF_IN_TEMP_HOT];
   wire sCool = syncB[`PSF_IN_TEMP_COOL];
   wire sBrownIn = syncB[`PSF_IN_BROWN_IN];
   wire sBrownOut = syncB[`PSF_IN_BROWN_OUT];
   wire sLineOv = syncB[`PSF_IN_LINE_OV];
   wire sLineUv = syncB[`PSF_IN_LINE_UV];
   wire sCap = syncB[`PSF_IN_CAP_LARGE];
   wire sHit = syncB[`PSF_IN_LIMIT_HIT];
   wire reqPulse = syncB[`PSF_IN_REQ] & ~reqPrev;

   // ----------------------------------------------------------------
   // Microsecond tick
   // ----------------------------------------------------------------
   logic [7:0] divCnt;
   wire tick = (divCnt == 8'(`PSF_TICK_CYC - 1));

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         divCnt <= 8'h00;
      else
         divCnt <= tick ? 8'h00 : divCnt + 8'h01;
   end

   // ----------------------------------------------------------------
   // State and timers
   // ----------------------------------------------------------------
   psf_state_e state;
   psf_state_e next_state;
   psf_count_t stateUs;
   psf_count_t reqGapUs;
   psf_count_t offUs;
   psf_count_t ovlUs;
   psf_count_t uvUs;
   logic [4:0] skipUs;
   logic [10:0] onCyc;
   logic [1:0] soaHits;
   logic supplyBlock;
   logic thermBlock;

   wire running = (state == PSF_PRIM) || (state == PSF_SLAVE);
   wire listening = (state == PSF_WAIT) || (state == PSF_PRIM);
   wire active = running || (state == PSF_WAIT);
   // Second request of a pair about 30 us after the first
   wire hsPair = reqPulse && (reqGapUs >= 24'(`PSF_HS_MIN_US))
                 && (reqGapUs <= 24'(`PSF_HS_MAX_US));
   wire lineInRange = sBrownIn && !sLineOv;
   wire latchClear = sClear || sLineUv;
   wire ovlTrip = ovlUs >= 24'(RESTART_ON_US);
   wire silenceTrip = reqGapUs >= 24'(SILENCE_US);
   wire brownTrip = uvUs >= 24'(BROWNOUT_US);
   wire supplyTrip = sOvc;
   wire thermLatchTrip = sHot && optThermalLatch;

   always_comb begin
      next_state = state;
      unique case (state)
         PSF_INIT: begin
            if (sShunt)
               next_state = PSF_LINE;
         end
         PSF_LINE: begin
            if (lineInRange)
               next_state = PSF_WAIT;
         end
         PSF_WAIT: begin
            if (hsPair)
               next_state = PSF_SLAVE;
            else if (stateUs >= 24'(RESTART_ON_US))
               next_state = PSF_PRIM;
         end
         PSF_PRIM: begin
            if (hsPair)
               next_state = PSF_SLAVE;
            else if (stateUs >= 24'(RESTART_ON_US))
               next_state = PSF_AROFF;
         end
         PSF_SLAVE: begin
            if (silenceTrip)
               next_state = PSF_AROFF;
            else if (ovlTrip)
               next_state = PSF_AROFF;
         end
         PSF_AROFF: begin
            if (sLineUv)
               next_state = PSF_LINE;
            else if (stateUs >= 24'(RESTART_OFF_US))
               next_state = PSF_LINE;
         end
         PSF_LATCH: begin
            if (latchClear)
               next_state = PSF_INIT;
         end
      endcase
      if (active) begin
         if (thermLatchTrip)
            next_state = PSF_LATCH;
         else if (supplyTrip)
            next_state = optSupplyLatch ? PSF_LATCH : PSF_AROFF;
         else if (sLineOv)
            next_state = PSF_AROFF;
         else if (brownTrip)
            next_state = PSF_AROFF;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         state <= PSF_INIT;
      else
         state <= next_state;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         stateUs <= '0;
      else if (state != next_state)
         stateUs <= '0;
      else if (tick)
         stateUs <= psfIncr(stateUs);
   end

   // Gap since last request; starts saturated so no pair is faked
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         reqGapUs <= 24'hffffff;
      else if (reqPulse)
         reqGapUs <= '0;
      else if (tick)
         reqGapUs <= psfIncr(reqGapUs);
   end

   // Overload time: grows while requests keep coming faster than the rate
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         ovlUs <= '0;
      else if (reqGapUs > 24'(OVL_GAP_US) || state != PSF_SLAVE)
         ovlUs <= '0;
      else if (tick)
         ovlUs <= psfIncr(ovlUs);
   end

   // Brown-out filter, held while the sense resistor is disconnected
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         uvUs <= '0;
      else if (!sBrownOut)
         uvUs <= '0;
      else if (tick && lineSenseOn)
         uvUs <= psfIncr(uvUs);
   end

   // ----------------------------------------------------------------
   // Supply and thermal blocks, current limit level choice
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         supplyBlock <= 1'b0;
         thermBlock <= 1'b0;
         ilimHigh <= 1'b0;
      end else begin
         if (sShunt)
            supplyBlock <= 1'b0;
         else if (sLow && state != PSF_INIT)
            supplyBlock <= 1'b1;
         if (sHot && !optThermalLatch)
            thermBlock <= 1'b1;
         else if (sCool)
            thermBlock <= 1'b0;
         if (state == PSF_INIT && sShunt)
            ilimHigh <= sCap;
      end
   end

   // ----------------------------------------------------------------
   // Switching cycle, SOA skip and line sense
   // ----------------------------------------------------------------
   wire canSwitch = running && !supplyBlock && !thermBlock && skipUs == 5'h00;
   wire primStart = (state == PSF_PRIM) && tick
                    && offUs >= 24'(PRIM_PERIOD_US);
   wire slaveStart = (state == PSF_SLAVE) && reqPulse;
   wire cycleStart = canSwitch && !switchOn && (primStart || slaveStart);
   wire onExpired = onCyc >= 11'(MAX_ON_CYC);
   wire cycleEnd = switchOn && (sHit || onExpired || !canSwitch);
   wire earlyHit = sHit && onCyc <= 11'(`PSF_SOA_CYC);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         switchOn <= 1'b0;
         onCyc <= 11'h000;
      end else if (cycleStart) begin
         switchOn <= 1'b1;
         onCyc <= 11'h000;
      end else if (cycleEnd) begin
         switchOn <= 1'b0;
      end else if (switchOn) begin
         onCyc <= onCyc + 11'h001;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         soaHits <= 2'h0;
         skipUs <= 5'h00;
      end else begin
         if (cycleEnd && earlyHit && soaHits == 2'h1) begin
            soaHits <= 2'h0;
            skipUs <= 5'(`PSF_T_SKIP_US);
         end else if (cycleEnd) begin
            soaHits <= earlyHit ? 2'h1 : 2'h0;
         end
         if (tick && skipUs != 5'h00 && !(cycleEnd && earlyHit))
            skipUs <= skipUs - 5'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         offUs <= '0;
      else if (switchOn)
         offUs <= '0;
      else if (tick)
         offUs <= psfIncr(offUs);
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         lineSenseOn <= 1'b1;
      else if (cycleStart)
         lineSenseOn <= 1'b1;
      else if (!switchOn && offUs >= 24'(`PSF_T_LINE_OFF_US))
         lineSenseOn <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Current limit ramp and jitter
   // ----------------------------------------------------------------
   // Limit falls with off time; long gaps keep only the floor
   psf_count_t drop;
   logic [6:0] base;
   logic [6:0] jittered;
   logic [2:0] jitDepth;
   logic jitDown;
   logic [15:0] jitUs;

   assign drop = offUs / 24'(RAMP_DIV_US);
   assign base = (drop >= 24'(`PSF_PEAK_CURRENT_LIMIT_FULL - `PSF_PEAK_CURRENT_LIMIT_FLOOR)) ?
                 `PSF_PEAK_CURRENT_LIMIT_FLOOR : `PSF_PEAK_CURRENT_LIMIT_FULL - drop[6:0];
   assign jittered = (base - {4'h0, jitDepth} < `PSF_PEAK_CURRENT_LIMIT_FLOOR) ?
                     `PSF_PEAK_CURRENT_LIMIT_FLOOR : base - {4'h0, jitDepth};

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         jitUs <= 16'h0000;
         jitDepth <= 3'h0;
         jitDown <= 1'b0;
      end else if (tick) begin
         if (jitUs >= 16'(JIT_STEP_US - 1)) begin
            jitUs <= 16'h0000;
            if (jitDown)
               jitDepth <= jitDepth - 3'h1;
            else
               jitDepth <= jitDepth + 3'h1;
            if (!jitDown && jitDepth == `PSF_JIT_DEPTH - 3'h1)
               jitDown <= 1'b1;
            else if (jitDown && jitDepth == 3'h1)
               jitDown <= 1'b0;
         end else begin
            jitUs <= jitUs + 16'h0001;
         end
      end
   end

   // Updated every clock so a request sees the current limit at once
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         ilimPct <= `PSF_PEAK_CURRENT_LIMIT_FULL;
      else
         ilimPct <= jittered;
   end

   // ----------------------------------------------------------------
   // Status
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         slaveMode <= 1'b0;
         autoRestart <= 1'b0;
         latchedOff <= 1'b0;
         fsmState <= PSF_INIT;
      end else begin
         slaveMode <= (next_state == PSF_SLAVE);
         autoRestart <= (next_state == PSF_AROFF);
         latchedOff <= (next_state == PSF_LATCH);
         fsmState <= next_state;
      end
   end

endmodule
`default_nettype wire

// *** tb/psf_sequencer_sva.sv ***
/*
 Concurrent assertions for the primary-side fault sequencer.
 Assumes it is bound to psf_sequencer and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none
`include "psf_map.svh"

module psf_sequencer_sva (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Watched inputs
   input wire logic supplyClear,
   input wire logic lineUnder,
   input wire logic tempHot,
   input wire logic limitHit,
   // Watched outputs
   input wire logic switchOn,
   input wire logic [6:0] ilimPct,
   input wire logic ilimHigh,
   input wire logic lineSenseOn,
   input wire logic slaveMode,
   input wire logic autoRestart,
   input wire logic latchedOff,
   input wire psf_pkg::psf_state_e fsmState
);
   import psf_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // ----------------------------------------------------------------
   // Named steps
   // ----------------------------------------------------------------
   // Three quiet samples cover the two synchroniser flops
   sequence s_quiet_latch;
      (latchedOff && !supplyClear && !lineUnder) [*3];
   endsequence
   sequence s_hit_while_on;
      $rose(limitHit) && switchOn;
   endsequence

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   slave_flag_a: assert property (slaveMode == (fsmState == PSF_SLAVE))
      else $error("slaveMode disagrees with state");
   restart_flag_a: assert property (autoRestart == (fsmState == PSF_AROFF))
      else $error("autoRestart disagrees with state");
   latch_flag_a: assert property (latchedOff == (fsmState == PSF_LATCH))
      else $error("latchedOff disagrees with state");
   turn_on_state_a: assert property ($rose(switchOn) |-> fsmState inside {PSF_PRIM, PSF_SLAVE})
      else $error("switch turned on outside a switching state");
   peak_current_limit_range_a: assert property (switchOn |-> ilimPct >= `PSF_PEAK_CURRENT_LIMIT_FLOOR && ilimPct <= `PSF_PEAK_CURRENT_LIMIT_FULL)
      else $error("current limit outside range while on");
   sense_reconnect_a: assert property ($rose(switchOn) |-> ##[0:2] lineSenseOn)
      else $error("line sense not back at cycle start");
   latch_hold_a: assert property (s_quiet_latch |=> latchedOff)
      else $error("latch left without a clear condition");
   off_no_switch_a: assert property ((autoRestart && $past(autoRestart)) || (latchedOff && $past(latchedOff)) |-> !switchOn)
      else $error("switch on during restart off or latch");
   line_reset_a: assert property ($rose(lineUnder) && autoRestart |-> ##[1:6] !autoRestart)
      else $error("line reset did not clear restart");
   thermal_stop_a: assert property ($rose(tempHot) |-> ##[1:6] !switchOn)
      else $error("switch still on after over-temperature");
   limit_stop_a: assert property (s_hit_while_on |-> ##[1:5] !switchOn)
      else $error("switch not off after limit hit");
   peak_current_limit_hold_a: assert property (fsmState != PSF_INIT && $past(fsmState) != PSF_INIT
      && $past(fsmState, 2) != PSF_INIT |-> $stable(ilimHigh))
      else $error("limit choice changed after latching");
endmodule

bind psf_sequencer psf_sequencer_sva chk (
   .clk_sys, .reset_n, .supplyClear, .lineUnder, .tempHot, .limitHit, .switchOn, .ilimPct,
   .ilimHigh, .lineSenseOn, .slaveMode, .autoRestart, .latchedOff, .fsmState
);
`default_nettype wire

// *** tb/psf_secondary_model.sv ***
/*
 Behavioural secondary-side controller that sends cycle requests.
 Assumes the bench enables it and sets the request period in clocks.
*/
`timescale 1ns/10ps
`default_nettype none

module psf_secondary_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Bench control
   input wire logic enable,
   input wire logic [15:0] periodCyc,
   // Primary side
   input wire logic switchOn,
   output logic cycleRequest
);
   // 30 us pair spacing, less the count's zero step
   localparam logic [15:0] HS_GAP = 16'hea5;
   logic [15:0] count;
   logic [15:0] gap;
   logic [1:0] hsLeft;
   logic [3:0] misses;
   logic [2:0] extras;
   logic pending;
   logic lastOn;
   assign gap = (hsLeft != 2'h0) ? HS_GAP : periodCyc;

   always @(negedge clk_sys or negedge reset_n) begin
      if (!reset_n || !enable) begin
         count <= 16'h0;
         hsLeft <= 2'h2;
         misses <= 4'h0;
         extras <= 3'h0;
         pending <= 1'b0;
         lastOn <= 1'b0;
         cycleRequest <= 1'b0;
      end else begin
         lastOn <= switchOn;
         // Four clocks high per request
         cycleRequest <= (count < 16'h4);
         count <= (count >= gap) ? 16'h0 : count + 16'h1;
         if (count == 16'h0) begin
            if (hsLeft != 2'h0) begin
               hsLeft <= hsLeft - 2'h1;
            end else begin
               pending <= 1'b1;
               misses <= pending ? misses + 4'h1 : misses;
            end
         end
         if (switchOn && !lastOn) begin
            pending <= 1'b0;
            misses <= 4'h0;
            extras <= pending ? 3'h0 : extras + 3'h1;
         end
         if (misses == 4'h8 || extras >= 3'h4) begin
            hsLeft <= 2'h2;
            misses <= 4'h0;
            extras <= 3'h0;
            pending <= 1'b0;
            count <= 16'h0;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/psf_sequencer_test.sv ***
/*
 Self-checking bench of the primary-side fault sequencer.
 Assumes the secondary model beside it and shortened timing parameters.
*/
`timescale 1ns/10ps
`default_nettype none
`include "psf_map.svh"

module psf_sequencer_test;
   import psf_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic supplyLow = 1'b0, supplyShunt = 1'b0, supplyClear = 1'b0, supplyOverCurrent = 1'b0;
   logic capLarge = 1'b0, tempHot = 1'b0, tempCool = 1'b1, lineBrownIn = 1'b0;
   logic lineBrownOut = 1'b0, lineOver = 1'b0, lineUnder = 1'b0, limitHit = 1'b0;
   logic optSupplyLatch = 1'b0, optThermalLatch = 1'b0, pEnable = 1'b0;
   logic [15:0] pPeriod = 16'h09c3;
   logic cycleRequest, switchOn, ilimHigh, lineSenseOn, slaveMode, autoRestart, latchedOff;
   logic [6:0] ilimPct;
   psf_state_e fsmState;
   int errorCnt = 0;
   int checksDone = 0;
   int onCnt = 0;

   psf_sequencer #(
      .RESTART_OFF_US(50),
      .SILENCE_US(120),
      .BROWNOUT_US(20),
      .RESTART_ON_US(100),
      .RAMP_DIV_US(1)
   ) dut (
      .clk_sys, .reset_n, .supplyLow, .supplyShunt, .supplyClear, .supplyOverCurrent, .capLarge,
      .tempHot, .tempCool, .lineBrownIn, .lineBrownOut, .lineOver, .lineUnder, .limitHit,
      .cycleRequest, .optSupplyLatch, .optThermalLatch, .switchOn, .ilimPct, .ilimHigh,
      .lineSenseOn, .slaveMode, .autoRestart, .latchedOff, .fsmState
   );
   psf_secondary_model partner (
      .clk_sys, .reset_n, .enable(pEnable), .periodCyc(pPeriod), .switchOn, .cycleRequest
   );

   initial forever #4 clk_sys = ~clk_sys;

   // Power stage: limit reached about 100 clocks into each cycle
   always @(negedge clk_sys) begin
      onCnt = switchOn ? onCnt + 1 : 0;
      limitHit = switchOn && (onCnt > 100);
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(string what, logic [23:0] seen, logic [23:0] expected);
      checksDone++;
      if (seen !== expected) begin
         errorCnt++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, expected, seen);
      end
   endtask
   task automatic wait_state(psf_state_e st, int maxCyc);
      int n = 0;
      while (fsmState !== st && n < maxCyc) begin
         @(negedge clk_sys);
         n++;
      end
   endtask
   task automatic wait_sw(logic level, int maxCyc);
      int n = 0;
      while (switchOn !== level && n < maxCyc) begin
         @(negedge clk_sys);
         n++;
      end
   endtask
   task automatic pulse_line_reset(psf_state_e st);
      lineUnder = 1'b1;
      wait_state(st, 8);
      lineUnder = 1'b0;
   endtask
   task automatic printVerdict();
      $display("Counts: %0d checks, %0d mismatches", checksDone, errorCnt);
      if (errorCnt == 0 && checksDone > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset();
      check("fsmState", fsmState, PSF_INIT);
      check("switchOn", switchOn, 1'b0);
      check("ilimPct", ilimPct, `PSF_PEAK_CURRENT_LIMIT_FULL);
      check("lineSenseOn", lineSenseOn, 1'b1);
      $display("test_reset done");
   endtask
   task automatic test_startup();
      capLarge = 1'b1;
      supplyShunt = 1'b1;
      wait_state(PSF_LINE, 10);
      check("ilimHigh", ilimHigh, 1'b1);
      capLarge = 1'b0;
      lineBrownIn = 1'b1;
      lineOver = 1'b1;
      repeat (50) @(negedge clk_sys);
      check("fsmState", fsmState, PSF_LINE);
      lineOver = 1'b0;
      wait_state(PSF_WAIT, 10);
      check("fsmState", fsmState, PSF_WAIT);
      pEnable = 1'b1;
      repeat (2000) @(negedge clk_sys);
      check("fsmState", fsmState, PSF_WAIT);
      check("switchOn", switchOn, 1'b0);
      wait_state(PSF_SLAVE, 2500);
      check("slaveMode", slaveMode, 1'b1);
      check("ilimHigh", ilimHigh, 1'b1);
      $display("test_startup done");
   endtask
   task automatic test_slave_switch();
      wait_sw(1'b1, 3000);
      wait_sw(1'b0, 200);
      wait_sw(1'b1, 3000);
      check("switchOn", switchOn, 1'b1);
      check("ilimPct ramp", ilimPct >= 7'h4a && ilimPct <= 7'h52, 1'b1);
      check("lineSenseOn", lineSenseOn, 1'b1);
      pPeriod = 16'h270f;
      wait_sw(1'b0, 200);
      repeat (6600) @(negedge clk_sys);
      check("lineSenseOn", lineSenseOn, 1'b0);
      wait_sw(1'b1, 4000);
      check("ilimPct", ilimPct, `PSF_PEAK_CURRENT_LIMIT_FLOOR);
      repeat (3) @(negedge clk_sys);
      check("lineSenseOn", lineSenseOn, 1'b1);
      $display("test_slave_switch done");
   endtask
   task automatic test_silence();
      pEnable = 1'b0;
      wait_state(PSF_AROFF, 16000);
      check("autoRestart", autoRestart, 1'b1);
      repeat (6000) @(negedge clk_sys);
      check("fsmState", fsmState, PSF_AROFF);
      wait_state(PSF_WAIT, 1000);
      check("fsmState", fsmState, PSF_WAIT);
      $display("test_silence done");
   endtask
   task automatic test_line_faults();
      lineOver = 1'b1;
      wait_state(PSF_AROFF, 20);
      check("autoRestart", autoRestart, 1'b1);
      pulse_line_reset(PSF_LINE);
      check("fsmState", fsmState, PSF_LINE);
      repeat (100) @(negedge clk_sys);
      check("fsmState", fsmState, PSF_LINE);
      lineOver = 1'b0;
      wait_state(PSF_WAIT, 10);
      pEnable = 1'b1;
      wait_sw(1'b1, 15000);
      lineBrownOut = 1'b1;
      lineBrownIn = 1'b0;
      repeat (2000) @(negedge clk_sys);
      check("fsmState", fsmState, PSF_SLAVE);
      wait_state(PSF_AROFF, 1000);
      check("autoRestart", autoRestart, 1'b1);
      lineBrownOut = 1'b0;
      pEnable = 1'b0;
      pulse_line_reset(PSF_LINE);
      repeat (100) @(negedge clk_sys);
      check("fsmState", fsmState, PSF_LINE);
      lineBrownIn = 1'b1;
      wait_state(PSF_WAIT, 10);
      check("fsmState", fsmState, PSF_WAIT);
      $display("test_line_faults done");
   endtask
   task automatic test_supply_thermal();
      supplyOverCurrent = 1'b1;
      wait_state(PSF_AROFF, 20);
      check("autoRestart", autoRestart, 1'b1);
      supplyOverCurrent = 1'b0;
      pulse_line_reset(PSF_LINE);
      wait_state(PSF_WAIT, 10);
      optSupplyLatch = 1'b1;
      supplyOverCurrent = 1'b1;
      wait_state(PSF_LATCH, 20);
      supplyOverCurrent = 1'b0;
      repeat (200) @(negedge clk_sys);
      check("latchedOff", latchedOff, 1'b1);
      supplyClear = 1'b1;
      wait_state(PSF_INIT, 10);
      check("fsmState", fsmState, PSF_INIT);
      supplyClear = 1'b0;
      wait_state(PSF_WAIT, 20);
      check("ilimHigh", ilimHigh, 1'b0);
      optThermalLatch = 1'b1;
      tempHot = 1'b1;
      tempCool = 1'b0;
      wait_state(PSF_LATCH, 20);
      tempHot = 1'b0;
      tempCool = 1'b1;
      repeat (200) @(negedge clk_sys);
      check("latchedOff", latchedOff, 1'b1);
      pulse_line_reset(PSF_INIT);
      check("fsmState", fsmState, PSF_INIT);
      $display("test_supply_thermal done");
   endtask

   initial begin
      repeat (20) @(negedge clk_sys);
      reset_n = 1'b1;
      @(negedge clk_sys);
      test_reset();
      test_startup();
      test_slave_switch();
      test_silence();
      test_line_faults();
      test_supply_thermal();
      printVerdict();
   end

   initial begin
      repeat (90000) @(posedge clk_sys);
      errorCnt++;
      $display("Watchdog expired");
      printVerdict();
   end
endmodule
`default_nettype wire
